// ==== qenc_pkg.sv ====
/*
 * Shared constants and types for the quadrature encoder counter.
 * Assumes a single 20 MHz core clock and an Avalon-MM slave port of 32-bit words.
 */
package qenc_pkg;
	localparam int unsigned core_clk_hz = 20_000_000;

	// Register byte offsets
	localparam logic [3:0] reg_ctrl = 4'h0;
	localparam logic [3:0] reg_count = 4'h4;
	localparam logic [3:0] reg_raw = 4'h8;
	localparam logic [3:0] reg_status = 4'hC;

	localparam logic [5:0] reg_mask = 6'h10;
	localparam logic [5:0] reg_pins = 6'h14;

	// Control register bit positions
	localparam int ctrl_updown_bit = 0;
	localparam int ctrl_filter_bit = 1;
	localparam int ctrl_idx_pol_bit = 2;
	localparam int ctrl_gate_en_bit = 3;
	localparam int ctrl_gate_pol_bit = 4;
	localparam int ctrl_arm_bit = 5;
	localparam int ctrl_hold_bit = 6;

	localparam logic [6:0] ctrl_reset_value = 7'h02;

	// Status / mask bit positions
	localparam int st_index_bit = 0;
	localparam int st_skip_bit = 1;
	localparam int st_step_bit = 2;
	localparam int status_width = 3;

	// Filter lengths in sample clocks
	localparam logic [3:0] filt_long = 4'hF;
	localparam logic [3:0] filt_short = 4'h3;

	localparam logic [31:0] bad_addr_data = 32'h0000_0000;

	// The last member is bit 0, so the order runs from bit 6 down to match the bit positions above
	typedef struct packed {
		logic hold;
		logic arm;
		logic gate_pol;
		logic gate_en;
		logic idx_pol;
		logic filter;
		logic updown;
	} ctrl_t;

	typedef struct packed {
		logic gate;
		logic index;
		logic phase_b;
		logic phase_a;
	} pins_t;

	typedef enum logic [1:0] {
		bus_idle = 2'b00,
		bus_answer = 2'b01
	} bus_state_t;
endpackage : qenc_pkg

// ==== quadrature_encoder_counter.sv ====
/*
 * One encoder channel: input synchronisers, glitch filters, quadrature or
 * up/down decoder, index zeroing, counters and an Avalon-MM register slave.
 * Assumes encoder pins are asynchronous to core_clk_in and that the bus master
 * holds each request until waitrequest is low.
 */
// The address map and the Avalon-MM slave port were left to the implementer.
// Behaviour
// - Inputs: phase A, B, index, index gate
// - Signed 32-bit count since last zeroing
// - Armed index clears count, drops arm
// - Raw total never cleared by index/hold
// - Hold bit keeps count zero; host releases
// - Mode bit: quadrature or up/down
// - Filter: 15 clocks, else 3 clocks
// - Inputs sampled on one sample clock
// - Index edge polarity selectable, armed only
// - Gate enable masks index by gate input
// - Gate polarity selects active level
// - Quadrature gives four counts per cycle
// - Up/down: A rising steps, B direction
module quadrature_encoder_counter (
	// Clock, reset, enable
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic clk_en_in,
	// Encoder pins
	input wire logic enc_a_in,
	input wire logic enc_b_in,
	input wire logic enc_index_in,
	input wire logic enc_gate_in,
	// Avalon-MM slave
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Interrupt and count view
	output logic irq_out,
	output logic [31:0] count_out
);
	qenc_pkg::ctrl_t ctrl;
	qenc_pkg::pins_t sync1, sync2, filt, filt_d;
	logic [3:0][3:0] stable_cnt;
	logic [31:0] count, raw;
	logic [qenc_pkg::status_width-1:0] status, mask;
	qenc_pkg::bus_state_t bus_state;

	// Two-flop synchronisers on every pin, sampled on the one clock
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (clk_en_in) begin
			sync1 <= {enc_gate_in, enc_index_in, enc_b_in, enc_a_in};
			sync2 <= sync1;
		end
	end

	// A change must stand for the full filter length before it is taken
	logic [3:0] filt_len;
	assign filt_len = ctrl.filter ? qenc_pkg::filt_long : qenc_pkg::filt_short;

	// A pin that falls back restarts its count, so a chattering edge never accumulates
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_filt
			always_ff @(posedge core_clk_in) begin
				if (srst_in) begin
					stable_cnt[gi] <= 4'h0;
					filt[gi] <= 1'b0;
				end else if (clk_en_in) begin
					if (sync2[gi] == filt[gi]) begin
						stable_cnt[gi] <= 4'h0;
					end else if (stable_cnt[gi] + 4'h1 >= filt_len) begin
						stable_cnt[gi] <= 4'h0;
						filt[gi] <= sync2[gi];
					end else begin
						stable_cnt[gi] <= stable_cnt[gi] + 4'h1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			filt_d <= '0;
		end else if (clk_en_in) begin
			filt_d <= filt;
		end
	end

	// Step decode
	logic step_up, step_dn, skip;
	logic [1:0] ab_now, ab_old;
	assign ab_now = {filt.phase_a, filt.phase_b};
	assign ab_old = {filt_d.phase_a, filt_d.phase_b};

	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		skip = 1'b0;
		if (ctrl.updown) begin
			if (filt.phase_a && !filt_d.phase_a) begin
				step_up = !filt.phase_b;
				step_dn = filt.phase_b;
			end
		end else if (ab_now != ab_old) begin
			// Gray sequence 00-01-11-10; every edge counts
			case ({ab_old, ab_now})
				4'b0001, 4'b0111, 4'b1110, 4'b1000: step_up = 1'b1;
				4'b0010, 4'b1011, 4'b1101, 4'b0100: step_dn = 1'b1;
				default: skip = 1'b1;
			endcase
		end
	end

	// Index event: selected edge, optional gate
	logic idx_edge, gate_ok, idx_event;
	assign idx_edge = ctrl.idx_pol ? (filt.index && !filt_d.index) : (!filt.index && filt_d.index);
	assign gate_ok = !ctrl.gate_en || (filt.gate ^ ctrl.gate_pol);
	assign idx_event = idx_edge && gate_ok && ctrl.arm;

	logic [31:0] delta;
	assign delta = step_up ? 32'h0000_0001 : (step_dn ? 32'hFFFF_FFFF : 32'h0000_0000);

	// Position count: hold wins, then index zeroing, then steps
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			count <= 32'h0000_0000;
		end else if (clk_en_in) begin
			if (ctrl.hold || idx_event) begin
				count <= 32'h0000_0000;
			end else begin
				count <= count + delta;
			end
		end
	end

	// Raw total is only cleared by the core reset
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			raw <= 32'h0000_0000;
		end else if (clk_en_in) begin
			raw <= raw + delta;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			count_out <= 32'h0000_0000;
		end else if (clk_en_in) begin
			count_out <= count;
		end
	end

	// Bus slave: one wait cycle, answer on the second edge
	logic bus_req, bus_hit;
	assign bus_req = avs_read_in || avs_write_in;
	assign bus_hit = bus_state == qenc_pkg::bus_answer;

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			bus_state <= qenc_pkg::bus_idle;
			avs_waitrequest_out <= 1'b1;
		end else if (clk_en_in) begin
			case (bus_state)
				qenc_pkg::bus_idle: begin
					if (bus_req) begin
						bus_state <= qenc_pkg::bus_answer;
						avs_waitrequest_out <= 1'b0;
					end
				end
				qenc_pkg::bus_answer: begin
					bus_state <= qenc_pkg::bus_idle;
					avs_waitrequest_out <= 1'b1;
				end
				default: begin
					bus_state <= qenc_pkg::bus_idle;
					avs_waitrequest_out <= 1'b1;
				end
			endcase
		end
	end

	logic wr_go, rd_go;
	assign wr_go = bus_hit && avs_write_in && avs_byteenable_in[0];
	// Reads act on the first edge of the request, while waitrequest is still high, so the data returned and the clear-on-read see the same status
	assign rd_go = bus_state == qenc_pkg::bus_idle && avs_read_in;

	// Control: arm drops on the index event; a host write arming in that cycle still wins
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			ctrl <= qenc_pkg::ctrl_reset_value;
		end else if (clk_en_in) begin
			if (idx_event) begin
				ctrl.arm <= 1'b0;
			end
			if (wr_go && avs_address_in == {2'b00, qenc_pkg::reg_ctrl}) begin
				ctrl <= qenc_pkg::ctrl_t'(avs_writedata_in[6:0]);
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			mask <= '0;
		end else if (clk_en_in && wr_go && avs_address_in == qenc_pkg::reg_mask) begin
			mask <= avs_writedata_in[qenc_pkg::status_width-1:0];
		end
	end

	// Sticky status, cleared by read; a new event in the read cycle survives
	logic [qenc_pkg::status_width-1:0] next_status, events;
	logic status_rd;
	assign status_rd = rd_go && avs_address_in == {2'b00, qenc_pkg::reg_status};
	always_comb begin
		events = '0;
		events[qenc_pkg::st_index_bit] = idx_event;
		events[qenc_pkg::st_skip_bit] = skip;
		events[qenc_pkg::st_step_bit] = step_up || step_dn;
		next_status = (status_rd ? '0 : status) | events;
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			status <= '0;
			irq_out <= 1'b0;
		end else if (clk_en_in) begin
			status <= next_status;
			irq_out <= |(next_status & mask);
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (clk_en_in && rd_go) begin
			case (avs_address_in)
				{2'b00, qenc_pkg::reg_ctrl}: avs_readdata_out <= {25'h0, ctrl};
				{2'b00, qenc_pkg::reg_count}: avs_readdata_out <= count;
				{2'b00, qenc_pkg::reg_raw}: avs_readdata_out <= raw;
				{2'b00, qenc_pkg::reg_status}: avs_readdata_out <= {29'h0, status};
				qenc_pkg::reg_mask: avs_readdata_out <= {29'h0, mask};
				qenc_pkg::reg_pins: avs_readdata_out <= {28'h0, filt};
				default: avs_readdata_out <= qenc_pkg::bad_addr_data;
			endcase
		end
	end

	// Assertions
	sequence idx_seq;
		idx_event;
	endsequence

	idx_zero_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		(clk_en_in and idx_seq) |=> count == 32'h0000_0000) else $error("count not zeroed by index");
	arm_drop_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && idx_event && !wr_go |=> !ctrl.arm) else $error("arm not dropped");
	hold_zero_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && ctrl.hold |=> count == 32'h0000_0000) else $error("hold did not zero count");
	raw_keep_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && (ctrl.hold || idx_event) |=> raw == $past(raw) + $past(delta)) else $error("raw total disturbed");
	no_arm_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && $past(clk_en_in) && idx_event
		|-> ctrl.arm && (ctrl.idx_pol ? $rose(filt.index) : $fell(filt.index)))
		else $error("index acted without armed selected edge");
	gate_block_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		ctrl.gate_en && (filt.gate == ctrl.gate_pol) |-> !idx_event) else $error("gated index acted");
	skip_none_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && skip && !ctrl.hold && !idx_event |=> count == $past(count))
		else $error("skipped state counted");
	updown_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		ctrl.updown && (step_up || step_dn) |-> $rose(filt.phase_a)) else $error("up/down step without A rise");
	filt_len_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && ctrl.filter && $changed(filt.phase_a) |-> $past(sync2.phase_a, 15) == filt.phase_a)
		else $error("filter took change too early");
	bus_ans_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && bus_req && avs_waitrequest_out && bus_state == qenc_pkg::bus_idle |=> !avs_waitrequest_out)
		else $error("bus answer late");

	// Steps and direction
	sequence quad_free_seq;
		!ctrl.updown && !ctrl.hold && !idx_event;
	endsequence

	sequence ud_rise_seq;
		ctrl.updown && $past(clk_en_in) && $rose(filt.phase_a);
	endsequence

	quad_up_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		(clk_en_in and quad_free_seq) ##0 step_up |=> count == $past(count) + 32'h0000_0001)
		else $error("quadrature up step lost");
	quad_dn_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		(clk_en_in and quad_free_seq) ##0 step_dn |=> count == $past(count) - 32'h0000_0001)
		else $error("quadrature down step lost");
	ud_dir_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		(clk_en_in and ud_rise_seq) |-> (filt.phase_b ? step_dn : step_up))
		else $error("up/down direction wrong");
	ud_quiet_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && ctrl.updown |-> !skip)
		else $error("skip flagged in up/down mode");
	count_view_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in |=> count_out == $past(count))
		else $error("count view lags");
	raw_step_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in |=> raw == $past(raw) + $past(delta))
		else $error("raw total missed a step");

	// Pins and filters
	sync_chain_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in |=> sync2 == $past(sync1))
		else $error("synchroniser skipped a stage");
	filt_min_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && $changed(filt.index) |-> $past(sync2.index, 3) == filt.index)
		else $error("index filter took change too early");

	// Index qualification
	gate_open_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && $past(clk_en_in) && ctrl.arm && ctrl.gate_en && (filt.gate != ctrl.gate_pol)
		&& $changed(filt.index) && (filt.index == ctrl.idx_pol) |-> idx_event)
		else $error("open gate blocked index");
	status_set_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		(clk_en_in and idx_seq) |=> status[qenc_pkg::st_index_bit])
		else $error("index event not recorded");

	// Bus, status and interrupt
	ctrl_write_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && wr_go && avs_address_in == {2'b00, qenc_pkg::reg_ctrl}
		|=> ctrl == $past(avs_writedata_in[6:0])) else $error("control write lost");
	st_clear_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && status_rd && events == '0 |=> status == '0)
		else $error("status not cleared by read");
	// The interrupt is registered, so it follows a mask write one edge late
	irq_level_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in |=> irq_out == |(status & $past(mask)))
		else $error("interrupt level wrong");
	wait_one_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && !avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	idle_wait_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		clk_en_in && !bus_req && bus_state == qenc_pkg::bus_idle |=> avs_waitrequest_out)
		else $error("waitrequest low while idle");
endmodule : quadrature_encoder_counter

// ==== enc_model.sv ====
/*
 * Encoder sensor model: two phases in Gray order, index and index-gate pins.
 * Assumes its tasks are called one at a time from the core clock domain.
 */
module enc_model (
	// Sample clock
	input wire logic core_clk_in,
	// Encoder pins
	output logic enc_a_out,
	output logic enc_b_out,
	output logic enc_index_out,
	output logic enc_gate_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pos = 2'b00;
	initial begin
		enc_a_out = 1'b0;
		enc_b_out = 1'b0;
		enc_index_out = 1'b0;
		enc_gate_out = 1'b0;
	end
	// Pins move just after an edge and then hold, so the hold sets the pulse width
	task automatic pins(input logic a, input logic b, input logic idx, input logic gate, input int hold);
		@(posedge core_clk_in);
		enc_a_out <= a;
		enc_b_out <= b;
		enc_index_out <= idx;
		enc_gate_out <= gate;
		repeat (hold) @(posedge core_clk_in);
	endtask : pins
	// Phase B leads when moving forward, which the counter takes as counting up
	task automatic step(input logic fwd, input int hold);
		pos = fwd ? pos + 2'd1 : pos - 2'd1;
		pins(pos[1], pos[1] ^ pos[0], enc_index_out, enc_gate_out, hold);
	endtask : step
	// Both phases flip together: a state is skipped
	task automatic jump(input int hold);
		pos = pos + 2'd2;
		pins(pos[1], pos[1] ^ pos[0], enc_index_out, enc_gate_out, hold);
	endtask : jump
endmodule : enc_model

// ==== tb_top.sv ====
/*
 * Testbench for the encoder counter: bus tasks, encoder scenarios, verdict.
 * Assumes enc_model drives the encoder pins and the slave answers each transfer by itself.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] a_ctrl = {2'h0, qenc_pkg::reg_ctrl};
	localparam logic [5:0] a_cnt = {2'h0, qenc_pkg::reg_count};
	localparam logic [5:0] a_raw = {2'h0, qenc_pkg::reg_raw};
	localparam logic [5:0] a_st = {2'h0, qenc_pkg::reg_status};
	logic core_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [5:0] avs_address_in = 6'h00;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out, count_out, rdata;
	logic avs_waitrequest_out, irq_out, enc_a, enc_b, enc_index, enc_gate;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	always #25 core_clk_in = ~core_clk_in;
	enc_model enc_model_i (.core_clk_in(core_clk_in), .enc_a_out(enc_a), .enc_b_out(enc_b),
		.enc_index_out(enc_index), .enc_gate_out(enc_gate));
	quadrature_encoder_counter quadrature_encoder_counter_i (.core_clk_in(core_clk_in), .srst_in(srst_in),
		.clk_en_in(1'b1), .enc_a_in(enc_a), .enc_b_in(enc_b), .enc_index_in(enc_index), .enc_gate_in(enc_gate),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .count_out(count_out));
	task automatic final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Request held until waitrequest is sampled low; only the bench timeout ends a dead wait
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0);
		rdata = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		check("bus latency", n, 32'h2);
	endtask : bus
	task automatic rd(input string name, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(name, rdata, exp);
	endtask : rd
	task automatic pulse;
		enc_model_i.pins(enc_a, enc_b, 1'b1, enc_gate, 8);
		enc_model_i.pins(enc_a, enc_b, 1'b0, enc_gate, 8);
	endtask : pulse
	task automatic updown(input logic dir);
		enc_model_i.pins(1'b1, dir, 1'b0, 1'b0, 8);
		enc_model_i.pins(1'b0, dir, 1'b0, 1'b0, 8);
	endtask : updown
	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge core_clk_in);
		srst_in <= 1'b0;
		check("irq reset", {31'h0, irq_out}, 32'h0);
		rd("ctrl reset", a_ctrl, 32'h2);
		bus(1'b1, a_ctrl, 32'h0);
		repeat (3) enc_model_i.step(1'b0, 8);
		rd("count negative", a_cnt, 32'hFFFF_FFFD);
		repeat (8) enc_model_i.step(1'b1, 8);
		rd("count forward", a_cnt, 32'h5);
		check("count view", count_out, 32'h5);
		bus(1'b0, a_st, 32'h0);
		enc_model_i.jump(8);
		rd("count after jump", a_cnt, 32'h5);
		bus(1'b0, a_st, 32'h0);
		check("skip flag", {31'h0, rdata[qenc_pkg::st_skip_bit]}, 32'h1);
		repeat (4) enc_model_i.step(1'b1, 8);
		rd("raw total", a_raw, 32'h9);
		enc_model_i.pins(~enc_a, enc_b, 1'b0, 1'b0, 1);
		enc_model_i.pins(~enc_a, enc_b, 1'b0, 1'b0, 8);
		rd("short glitch", a_cnt, 32'h9);
		bus(1'b1, a_ctrl, 32'h2);
		enc_model_i.pins(~enc_a, enc_b, 1'b0, 1'b0, 10);
		enc_model_i.pins(~enc_a, enc_b, 1'b0, 1'b0, 24);
		rd("long glitch", a_cnt, 32'h9);
		enc_model_i.step(1'b1, 24);
		rd("filtered step", a_cnt, 32'hA);
		bus(1'b1, qenc_pkg::reg_mask, 32'h1);
		bus(1'b0, a_st, 32'h0);
		bus(1'b1, a_ctrl, 32'h24);
		pulse();
		rd("index zero", a_cnt, 32'h0);
		rd("arm dropped", a_ctrl, 32'h4);
		rd("raw kept", a_raw, 32'hA);
		check("irq set", {31'h0, irq_out}, 32'h1);
		bus(1'b0, a_st, 32'h0);
		check("index flag", {31'h0, rdata[qenc_pkg::st_index_bit]}, 32'h1);
		repeat (2) @(posedge core_clk_in);
		check("irq clear", {31'h0, irq_out}, 32'h0);
		repeat (2) enc_model_i.step(1'b1, 8);
		pulse();
		rd("unarmed", a_cnt, 32'h2);
		check("irq masked", {31'h0, irq_out}, 32'h0);
		bus(1'b1, a_ctrl, 32'h20);
		enc_model_i.pins(enc_a, enc_b, 1'b1, 1'b0, 8);
		rd("rise ignored", a_cnt, 32'h2);
		enc_model_i.pins(enc_a, enc_b, 1'b0, 1'b0, 8);
		rd("fall zero", a_cnt, 32'h0);
		enc_model_i.step(1'b1, 8);
		bus(1'b1, a_ctrl, 32'h2C);
		pulse();
		rd("gate closed", a_cnt, 32'h1);
		rd("arm kept", a_ctrl, 32'h2C);
		bus(1'b1, a_ctrl, 32'h3C);
		pulse();
		rd("gate active low", a_cnt, 32'h0);
		repeat (2) enc_model_i.step(1'b1, 8);
		bus(1'b1, a_ctrl, 32'h40);
		repeat (3) enc_model_i.step(1'b1, 8);
		rd("hold zero", a_cnt, 32'h0);
		rd("raw runs", a_raw, 32'h12);
		bus(1'b1, a_ctrl, 32'h0);
		enc_model_i.step(1'b1, 8);
		rd("hold released", a_cnt, 32'h1);
		bus(1'b1, a_ctrl, 32'h1);
		enc_model_i.pins(1'b0, 1'b0, 1'b0, 1'b0, 8);
		repeat (3) updown(1'b0);
		enc_model_i.pins(1'b0, 1'b1, 1'b0, 1'b0, 8);
		repeat (2) updown(1'b1);
		rd("up down", a_cnt, 32'h2);
		rd("unmapped", 6'h3C, qenc_pkg::bad_addr_data);
		final_report();
	end
endmodule : tb_top
